// file: analog_extreme_tracker.sv
// One analog channel: current, lowest and highest raw and converted values.
// Assumes samples arrive as a valid strobe with raw word and IEEE single float.
`timescale 1ns/100ps
`default_nettype none
module analog_extreme_tracker (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic sample_valid,
    input wire logic [15:0] sample_raw,
    input wire logic [31:0] sample_converted,
    input wire logic clear,
    output logic [15:0] raw_now,
    output logic [15:0] raw_lowest,
    output logic [15:0] raw_highest,
    output logic [31:0] converted_now,
    output logic [31:0] converted_lowest,
    output logic [31:0] converted_highest
);
    // Sign-magnitude ordering; plus and minus zero compare equal.
    function automatic logic f_less(input logic [31:0] a, input logic [31:0] b);
        logic both_zero;
        both_zero = (a[30:0] == 31'h0) && (b[30:0] == 31'h0);
        if (a[31] != b[31]) return a[31] && !both_zero;
        if (!a[31]) return a[30:0] < b[30:0];
        return a[30:0] > b[30:0];
    endfunction : f_less

    wire [15:0] raw_in = sample_valid ? sample_raw : raw_now;
    wire [31:0] conv_in = sample_valid ? sample_converted : converted_now;
    wire raw_lo_take = clear || (sample_valid && sample_raw < raw_lowest);
    wire raw_hi_take = clear || (sample_valid && sample_raw > raw_highest);
    wire cv_lo_take = clear || (sample_valid && f_less(sample_converted, converted_lowest));
    wire cv_hi_take = clear || (sample_valid && f_less(converted_highest, sample_converted));

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            raw_now <= io_status_pkg::RAW_HIGH_RESET;
            raw_lowest <= io_status_pkg::RAW_LOW_RESET;
            raw_highest <= io_status_pkg::RAW_HIGH_RESET;
            converted_now <= '0;
            converted_lowest <= io_status_pkg::CONV_LOW_RESET;
            converted_highest <= io_status_pkg::CONV_HIGH_RESET;
        end else begin
            raw_now <= raw_in;
            converted_now <= conv_in;
            if (raw_lo_take) raw_lowest <= raw_in;
            if (raw_hi_take) raw_highest <= raw_in;
            if (cv_lo_take) converted_lowest <= conv_in;
            if (cv_hi_take) converted_highest <= conv_in;
        end
    end

    raw_low_track_a: assert property (@(posedge clock) disable iff (!rst_n)
        sample_valid && !clear |=> raw_lowest <= $past(sample_raw))
        else $error("raw lowest missed a smaller sample");
    raw_high_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
        !sample_valid && !clear |=> $stable(raw_highest))
        else $error("raw highest changed without sample or clear");
endmodule : analog_extreme_tracker
`default_nettype wire

// file: host_frame_sink.sv
// Host-side model that accepts the status datagram byte stream and keeps the last frame.
// Assumes it sits on the builder's byte output and shares its clock and reset.
`timescale 1ns/100ps
`default_nettype none
module host_frame_sink (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] out_data,
    input wire logic out_valid,
    input wire logic out_first,
    input wire logic out_last,
    input wire logic slow,
    output logic out_ready
);
    logic [7:0] rx [0:127];
    logic [4:0] pins_seen = 5'h00;
    int n_rx = 0;
    int n_frames = 0;

    // A slow host stalls every other cycle so the builder must hold each byte.
    always @(negedge clock) begin
        out_ready <= rst_n && (slow ? ~out_ready : 1'b1);
    end

    always @(posedge clock) begin
        if (out_valid && out_ready) begin
            if (out_first) begin
                n_rx = 0;
            end
            rx[n_rx] = out_data;
            n_rx = n_rx + 1;
            if (out_last) begin
                n_frames = n_frames + 1;
                pins_seen = rx[n_rx-2][4:0] & rx[n_rx-1][4:0];
            end
        end
    end
endmodule : host_frame_sink
`default_nettype wire

// file: interval_tick.sv
// Interval divider producing a one-cycle send request pulse.
// Assumes the period input is static while enabled; zero acts as one.
`timescale 1ns/100ps
`default_nettype none
module interval_tick #(
    parameter int WIDTH = 32
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic [WIDTH-1:0] period,
    output logic tick
);
    generate
        if (WIDTH < 2 || WIDTH > 32) begin : g_bad
            $error("interval_tick: WIDTH out of range");
        end
    endgenerate

    logic [WIDTH-1:0] count_reg;
    wire wrap = (count_reg + WIDTH'(1)) >= period;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            count_reg <= '0;
            tick <= 1'b0;
        end else if (!enable) begin
            count_reg <= '0;
            tick <= 1'b0;
        end else begin
            count_reg <= wrap ? '0 : count_reg + WIDTH'(1);
            tick <= wrap;
        end
    end

    tick_single_a: assert property (@(posedge clock) disable iff (!rst_n)
        tick && period > WIDTH'(1) |=> !tick)
        else $error("send pulse lasted more than one cycle");
endmodule : interval_tick
`default_nettype wire

// file: io_status_datagram_builder.sv
// Builds the periodic I/O status datagram as a byte stream, one byte per beat.
// Assumes a downstream transport that takes a byte when out_valid and out_ready.
//
// Behaviour
// - Order: version, total length, analog, digital/relay, serial control-pin sections.
// - Version byte carries the datagram layout revision identifier.
// - Two-byte fields go out most significant byte first.
// - Four-byte floats are IEEE single precision, most significant byte first.
// - Analog section: two-byte length growing 18 per enabled channel, enable byte.
// - Analog enable bit 0 is channel 1; 1 enabled, 0 disabled.
// - Disabled analog channels contribute no record.
// - Record: raw now, lowest, highest words, then converted now, lowest, highest.
// - Lowest and highest values hold extremes until cleared.
// - Variant without analog channels sends no analog records.
// - Digital/relay section always sent: length, enable byte, status byte.
// - Digital enable bit 0 is channel 1; 1 enabled, 0 disabled.
// - Digital status bit 1 means on, reversed for inverted channels.
// - Serial section always sent; bits 0..4 are DSR, DCD, CTS, DTR, RTS.
// - Pin enable bit set only with control profile and pin enabled.
// - Pin level bit 1 when pin high, 0 when low.
// - Datagram sent unprompted at the configured interval.
`timescale 1ns/100ps
`default_nettype none
module io_status_datagram_builder #(
    parameter int AN_COUNT = 4,
    parameter int DIG_COUNT = 4,
    parameter logic [7:0] FORMAT_VERSION = 8'h01
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic send_enable,
    input wire logic [31:0] interval_cycles,
    input wire logic [3:0] an_sample_valid,
    input wire logic [15:0] an_raw [4],
    input wire logic [31:0] an_converted [4],
    input wire logic [3:0] an_clear,
    input wire logic [3:0] an_enable,
    input wire logic [7:0] dig_enable,
    input wire logic [7:0] dig_on,
    input wire logic [7:0] dig_invert,
    input wire logic pin_profile_control,
    input wire logic [4:0] pin_enable,
    input wire logic [4:0] pin_level,
    input wire logic out_ready,
    output logic [7:0] out_data,
    output logic out_valid,
    output logic out_first,
    output logic out_last,
    output logic busy
);
    generate
        if (AN_COUNT < 0 || AN_COUNT > io_status_pkg::AN_PORTS) begin : g_bad_an
            $error("io_status_datagram_builder: AN_COUNT out of range");
        end
        if (DIG_COUNT < 0 || DIG_COUNT > io_status_pkg::DIG_PORTS) begin : g_bad_dig
            $error("io_status_datagram_builder: DIG_COUNT out of range");
        end
    endgenerate

    localparam logic [3:0] AN_IMPL = 4'((1 << AN_COUNT) - 1);
    localparam logic [7:0] DIG_IMPL = 8'((1 << DIG_COUNT) - 1);

    // Lowest enabled channel at or above 'from'; bit 2 flags a find.
    function automatic logic [2:0] next_chan(input logic [3:0] m, input logic [2:0] from);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 3; i >= 0; i--) begin
            if (m[i] && i >= int'(from)) r = {1'b1, 2'(i)};
        end
        return r;
    endfunction : next_chan

    function automatic logic [15:0] pop4(input logic [3:0] m);
        return 16'(m[0]) + 16'(m[1]) + 16'(m[2]) + 16'(m[3]);
    endfunction : pop4

    io_status_pkg::frame_state_t state_reg, state_next;
    logic [4:0] idx_reg, idx_next;
    logic [1:0] ch_reg, ch_next;
    logic pending_reg;
    logic send_tick;
    logic [3:0] an_mask_snap;
    logic [15:0] alen_snap;
    logic [15:0] total_snap;
    logic [7:0] dig_en_snap, dig_stat_snap;
    logic [4:0] pin_en_snap, pin_lvl_snap;
    logic [143:0] rec_live [4];
    logic [143:0] rec_snap [4];

    interval_tick #(
        .WIDTH(32)
    ) u_tick (
        .clock(clock),
        .rst_n(rst_n),
        .enable(send_enable),
        .period(interval_cycles),
        .tick(send_tick)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_chan
            logic [15:0] rn, rl, rh;
            logic [31:0] cn, cl, ch;
            analog_extreme_tracker u_track (
                .clock(clock),
                .rst_n(rst_n),
                .sample_valid(an_sample_valid[gi]),
                .sample_raw(an_raw[gi]),
                .sample_converted(an_converted[gi]),
                .clear(an_clear[gi]),
                .raw_now(rn),
                .raw_lowest(rl),
                .raw_highest(rh),
                .converted_now(cn),
                .converted_lowest(cl),
                .converted_highest(ch)
            );
            assign rec_live[gi] = {rn, rl, rh, cn, cl, ch};
        end
    endgenerate

    wire load = !out_valid || out_ready;
    wire step = (state_reg != io_status_pkg::ST_IDLE) && load;
    // A new frame waits until the last byte is taken, so no snapshot changes under it.
    wire start = (state_reg == io_status_pkg::ST_IDLE) && pending_reg && send_enable && load;
    wire at_head = state_reg == io_status_pkg::ST_HEAD;
    wire at_tail = state_reg == io_status_pkg::ST_TAIL;

    // Enable mask, unimplemented channels forced clear.
    wire [3:0] an_mask_live = an_enable & AN_IMPL;
    // Section length counts 18 bytes per enabled channel.
    wire [15:0] alen_live = 16'(io_status_pkg::AN_HDR_BYTES
        + io_status_pkg::RECORD_BYTES * pop4(an_mask_live));
    wire [15:0] total_live = 16'(io_status_pkg::FRAME_FIXED_BYTES + alen_live
        + io_status_pkg::DIG_SECT_LEN + io_status_pkg::SER_SECT_LEN);
    // Inverted channels report the opposite sense.
    wire [7:0] dig_stat_live = (dig_on ^ dig_invert) & DIG_IMPL;
    // Pin enable needs the control profile.
    wire [4:0] pin_en_live = pin_enable & {5{pin_profile_control}};

    wire [2:0] first_ch = next_chan(an_mask_snap, 3'h0);
    wire [2:0] later_ch = next_chan(an_mask_snap, 3'({1'b0, ch_reg}) + 3'h1);

    // Header: version, total length, analog length, analog enable.
    wire [47:0] head_vec = {FORMAT_VERSION, total_snap, alen_snap, 4'h0, an_mask_snap};
    // Tail sections with unused high bits zero.
    wire [63:0] tail_vec = {io_status_pkg::DIG_SECT_LEN, dig_en_snap, dig_stat_snap,
        io_status_pkg::SER_SECT_LEN, 3'h0, pin_en_snap, 3'h0, pin_lvl_snap};
    // Each vector is walked from its top byte downward.
    wire [7:0] head_byte = head_vec[8 * (5 - int'(idx_reg[2:0])) +: 8];
    wire [7:0] tail_byte = tail_vec[8 * (7 - int'(idx_reg[2:0])) +: 8];
    // Floats leave sign and exponent byte first.
    wire [7:0] rec_byte = rec_snap[ch_reg][8 * (17 - int'(idx_reg)) +: 8];
    wire [7:0] cur_byte = at_head ? head_byte : (at_tail ? tail_byte : rec_byte);

    // Request stays pending until a frame starts; a new tick wins.
    always_ff @(posedge clock) begin
        if (!rst_n) pending_reg <= 1'b0;
        else pending_reg <= send_tick || (pending_reg && !start);
    end

    // Snapshot at frame start so a datagram never mixes two sample instants.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            an_mask_snap <= '0;
            alen_snap <= io_status_pkg::AN_HDR_BYTES;
            total_snap <= '0;
            dig_en_snap <= '0;
            dig_stat_snap <= '0;
            pin_en_snap <= '0;
            pin_lvl_snap <= '0;
        end else if (start) begin
            an_mask_snap <= an_mask_live;
            alen_snap <= alen_live;
            total_snap <= total_live;
            dig_en_snap <= dig_enable & DIG_IMPL;
            dig_stat_snap <= dig_stat_live;
            pin_en_snap <= pin_en_live;
            // Levels copied as driven, high is one.
            pin_lvl_snap <= pin_level;
        end
    end

    always_ff @(posedge clock) begin
        if (start) rec_snap <= rec_live;
    end

    always_comb begin
        state_next = state_reg;
        idx_next = idx_reg;
        ch_next = ch_reg;
        unique case (state_reg)
            io_status_pkg::ST_IDLE: begin
                if (start) begin
                    state_next = io_status_pkg::ST_HEAD;
                    idx_next = '0;
                end
            end
            io_status_pkg::ST_HEAD: begin
                if (step && idx_reg == io_status_pkg::HEAD_LAST) begin
                    // No enabled channel means straight to the tail.
                    state_next = first_ch[2] ? io_status_pkg::ST_RECORD
                        : io_status_pkg::ST_TAIL;
                    ch_next = first_ch[1:0];
                    idx_next = '0;
                end else if (step) begin
                    idx_next = idx_reg + 5'h1;
                end
            end
            io_status_pkg::ST_RECORD: begin
                if (step && idx_reg == io_status_pkg::RECORD_LAST) begin
                    state_next = later_ch[2] ? io_status_pkg::ST_RECORD
                        : io_status_pkg::ST_TAIL;
                    ch_next = later_ch[2] ? later_ch[1:0] : ch_reg;
                    idx_next = '0;
                end else if (step) begin
                    idx_next = idx_reg + 5'h1;
                end
            end
            io_status_pkg::ST_TAIL: begin
                // Tail always follows, whatever the variant.
                if (step && idx_reg == io_status_pkg::TAIL_LAST) begin
                    state_next = io_status_pkg::ST_IDLE;
                    idx_next = '0;
                end else if (step) begin
                    idx_next = idx_reg + 5'h1;
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg <= io_status_pkg::ST_IDLE;
            idx_reg <= '0;
            ch_reg <= '0;
            busy <= 1'b0;
        end else begin
            state_reg <= state_next;
            idx_reg <= idx_next;
            ch_reg <= ch_next;
            busy <= state_next != io_status_pkg::ST_IDLE;
        end
    end

    // A byte is held until taken; the next one is loaded in the same cycle.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_data <= '0;
            out_first <= 1'b0;
            out_last <= 1'b0;
        end else if (load) begin
            out_valid <= step;
            out_data <= step ? cur_byte : 8'h00;
            out_first <= step && at_head && idx_reg == 5'h0;
            out_last <= step && at_tail && idx_reg == io_status_pkg::TAIL_LAST;
        end
    end

    // Byte position of the beat on offer, for the checks below.
    logic [15:0] pos_reg;
    always_ff @(posedge clock) begin
        if (!rst_n) pos_reg <= '0;
        else if (out_valid && out_ready) pos_reg <= out_last ? 16'h0 : pos_reg + 16'h1;
    end

    version_first_a: assert property (@(posedge clock) disable iff (!rst_n)
        out_valid && out_first |-> out_data == FORMAT_VERSION && pos_reg == 16'h0)
        else $error("first byte is not the version");
    total_len_msb_a: assert property (@(posedge clock) disable iff (!rst_n)
        out_valid && pos_reg == 16'h1 |-> out_data == total_snap[15:8])
        else $error("total length high byte misplaced");
    frame_length_a: assert property (@(posedge clock) disable iff (!rst_n)
        out_valid && out_last |-> pos_reg + 16'h1 == total_snap)
        else $error("frame length differs from header");
    analog_len_a: assert property (@(posedge clock) disable iff (!rst_n)
        out_valid && pos_reg == 16'h4 |-> out_data == alen_snap[7:0]
        && alen_snap == 16'(16'h3 + 16'h12 * pop4(an_mask_snap)))
        else $error("analog section length wrong");
    analog_mask_a: assert property (@(posedge clock) disable iff (!rst_n)
        out_valid && pos_reg == 16'h5 |-> out_data[7:4] == 4'h0
        && (out_data[3:0] & ~AN_IMPL) == 4'h0)
        else $error("analog enable has stray bits");
    record_enabled_a: assert property (@(posedge clock) disable iff (!rst_n)
        state_reg == io_status_pkg::ST_RECORD |-> an_mask_snap[ch_reg])
        else $error("record emitted for disabled channel");
    pin_byte_a: assert property (@(posedge clock) disable iff (!rst_n)
        start |=> pin_en_snap == ($past(pin_enable) & {5{$past(pin_profile_control)}}))
        else $error("pin enable byte ignores the profile");
    pin_level_last_a: assert property (@(posedge clock) disable iff (!rst_n)
        out_valid && out_last |-> out_data == {3'h0, pin_lvl_snap})
        else $error("pin level byte wrong");
    start_on_tick_a: assert property (@(posedge clock) disable iff (!rst_n)
        send_tick && send_enable && state_reg == io_status_pkg::ST_IDLE && !out_valid
        ##1 send_enable |=> state_reg == io_status_pkg::ST_HEAD)
        else $error("interval tick did not start a frame");
    hold_stall_a: assert property (@(posedge clock) disable iff (!rst_n)
        out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("byte dropped under back-pressure");
endmodule : io_status_datagram_builder
`default_nettype wire

// file: io_status_datagram_builder_tb.sv
// Self-checking bench for the status datagram builder with a host sink model.
// Assumes four analog and four digital channels and a short send interval.
`timescale 1ns/100ps
`default_nettype none
module io_status_datagram_builder_tb;
    localparam logic [7:0] VER = 8'h01;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic send_enable = 1'b0;
    logic [31:0] interval_cycles = 32'h00000014;
    logic [3:0] an_sample_valid = 4'h0;
    logic [15:0] an_raw [4] = '{default: 16'h0000};
    logic [31:0] an_converted [4] = '{default: 32'h00000000};
    logic [3:0] an_clear = 4'h0;
    logic [3:0] an_enable = 4'h0;
    logic [7:0] dig_enable = 8'h00;
    logic [7:0] dig_on = 8'h00;
    logic [7:0] dig_invert = 8'h00;
    logic prof = 1'b0;
    logic [4:0] pin_enable = 5'h00;
    logic [4:0] pin_level = 5'h00;
    logic slow = 1'b0;
    logic out_ready;
    logic [7:0] out_data;
    logic out_valid;
    logic out_first;
    logic out_last;
    logic busy;
    logic [15:0] e_rnow [4] = '{default: 16'h0000};
    logic [15:0] e_rlo [4] = '{default: 16'hffff};
    logic [15:0] e_rhi [4] = '{default: 16'h0000};
    logic [31:0] e_cnow [4] = '{default: 32'h00000000};
    logic [31:0] e_clo [4] = '{default: 32'h7f800000};
    logic [31:0] e_chi [4] = '{default: 32'hff800000};
    logic [7:0] exp_q [$];
    bit timed_out = 1'b0;
    int mismatches = 0;
    int n_checks = 0;

    always #4 clock = ~clock;

    io_status_datagram_builder #(.AN_COUNT(4), .DIG_COUNT(4), .FORMAT_VERSION(VER)) DUT (
        .clock(clock), .rst_n(rst_n), .send_enable(send_enable),
        .interval_cycles(interval_cycles), .an_sample_valid(an_sample_valid),
        .an_raw(an_raw), .an_converted(an_converted), .an_clear(an_clear),
        .an_enable(an_enable), .dig_enable(dig_enable), .dig_on(dig_on),
        .dig_invert(dig_invert), .pin_profile_control(prof), .pin_enable(pin_enable),
        .pin_level(pin_level), .out_ready(out_ready), .out_data(out_data),
        .out_valid(out_valid), .out_first(out_first), .out_last(out_last), .busy(busy));

    host_frame_sink partner (
        .clock(clock), .rst_n(rst_n), .out_data(out_data), .out_valid(out_valid),
        .out_first(out_first), .out_last(out_last), .slow(slow), .out_ready(out_ready));

    task check(input string what, input logic [31:0] seen, input logic [31:0] expv);
        n_checks++;
        if (seen !== expv) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, expv, seen);
        end
    endtask : check

    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    task put16(input logic [15:0] v);
        exp_q.push_back(v[15:8]);
        exp_q.push_back(v[7:0]);
    endtask : put16

    task put32(input logic [31:0] v);
        put16(v[31:16]);
        put16(v[15:0]);
    endtask : put32

    task build_expected;
        int n;
        n = 0;
        exp_q = {};
        for (int i = 0; i < 4; i++) n += an_enable[i];
        exp_q.push_back(VER);
        put16(16'(14 + 18 * n));
        put16(16'(3 + 18 * n));
        exp_q.push_back({4'h0, an_enable});
        for (int i = 0; i < 4; i++) begin
            if (an_enable[i]) begin
                put16(e_rnow[i]);
                put16(e_rlo[i]);
                put16(e_rhi[i]);
                put32(e_cnow[i]);
                put32(e_clo[i]);
                put32(e_chi[i]);
            end
        end
        put16(16'h0004);
        exp_q.push_back({4'h0, dig_enable[3:0]});
        exp_q.push_back({4'h0, dig_on[3:0] ^ dig_invert[3:0]});
        put16(16'h0004);
        exp_q.push_back({3'h0, pin_enable & {5{prof}}});
        exp_q.push_back({3'h0, pin_level});
    endtask : build_expected

    // Positive floats only, so their bit patterns order like the values.
    task sample(input int ch, input logic [15:0] raw, input logic [31:0] conv);
        an_raw[ch] = raw;
        an_converted[ch] = conv;
        an_sample_valid[ch] = 1'b1;
        @(negedge clock);
        an_sample_valid[ch] = 1'b0;
        @(negedge clock);
        e_rnow[ch] = raw;
        e_cnow[ch] = conv;
        if (raw < e_rlo[ch]) e_rlo[ch] = raw;
        if (raw > e_rhi[ch]) e_rhi[ch] = raw;
        if (conv < e_clo[ch]) e_clo[ch] = conv;
        if (e_chi[ch][31] || conv > e_chi[ch]) e_chi[ch] = conv;
    endtask : sample

    task clear_ch(input int ch);
        an_clear[ch] = 1'b1;
        @(negedge clock);
        an_clear[ch] = 1'b0;
        @(negedge clock);
        e_rlo[ch] = e_rnow[ch];
        e_rhi[ch] = e_rnow[ch];
        e_clo[ch] = e_cnow[ch];
        e_chi[ch] = e_cnow[ch];
    endtask : clear_ch

    // The frame must arrive unprompted once sending is on.
    task get_frame(input logic slow_in);
        int f0;
        int k;
        logic seen_busy;
        logic [4:0] pins_exp;
        f0 = partner.n_frames;
        seen_busy = 1'b0;
        pins_exp = pin_enable & pin_level & {5{prof}};
        slow = slow_in;
        build_expected();
        send_enable = 1'b1;
        k = 0;
        while (partner.n_frames == f0 && k < 4000) begin
            @(negedge clock);
            seen_busy = seen_busy | busy;
            k++;
        end
        send_enable = 1'b0;
        if (k >= 4000) begin
            mismatches++;
            timed_out = 1'b1;
            return;
        end
        check("frame length", 32'(partner.n_rx), 32'(exp_q.size()));
        for (k = 0; k < exp_q.size(); k++) begin
            check("frame byte", {24'h0, partner.rx[k]}, {24'h0, exp_q[k]});
        end
        check("pins kept", {27'h0, partner.pins_seen}, {27'h0, pins_exp});
        check("busy seen", {31'h0, seen_busy}, 32'h1);
        repeat (4) @(negedge clock);
        k = 0;
        while ((busy || out_valid) && k < 200) begin
            @(negedge clock);
            k++;
        end
        check("idle after frame", {30'h0, busy, out_valid}, 32'h0);
    endtask : get_frame

    task scen_mixed;
        for (int i = 0; i < 4; i++) begin
            sample(i, 16'h2000 + 16'(i), 32'h40000000);
            sample(i, 16'h0800 + 16'(i), 32'h3f000000);
            sample(i, 16'h1000 + 16'(i), 32'h3f800000);
        end
        an_enable = 4'h5;
        dig_enable = 8'hff;
        dig_on = 8'h35;
        dig_invert = 8'h0f;
        prof = 1'b1;
        pin_enable = 5'h15;
        pin_level = 5'h0b;
        get_frame(1'b0);
    endtask : scen_mixed

    task scen_clear_slow;
        clear_ch(0);
        sample(2, 16'h0010, 32'h3e800000);
        an_enable = 4'hf;
        dig_enable = 8'h0a;
        prof = 1'b0;
        pin_level = 5'h1f;
        get_frame(1'b1);
    endtask : scen_clear_slow

    task scen_no_analog;
        an_enable = 4'h0;
        dig_invert = 8'h00;
        prof = 1'b1;
        pin_enable = 5'h1f;
        pin_level = 5'h12;
        get_frame(1'b0);
    endtask : scen_no_analog

    initial begin
        repeat (16) @(negedge clock);
        rst_n = 1'b1;
        @(negedge clock);
        scen_mixed();
        if (!timed_out) scen_clear_slow();
        if (!timed_out) scen_no_analog();
        tally_and_finish();
    end
endmodule : io_status_datagram_builder_tb
`default_nettype wire

// file: io_status_pkg.sv
// Shared constants and types for the I/O status datagram builder.
// Assumes a single clock domain; nothing here holds state.
package io_status_pkg;
    localparam int AN_PORTS = 4;
    localparam int DIG_PORTS = 8;
    localparam int PIN_PORTS = 5;
    localparam int PIN_DSR = 0;
    localparam int PIN_DCD = 1;
    localparam int PIN_CTS = 2;
    localparam int PIN_DTR = 3;
    localparam int PIN_RTS = 4;
    localparam logic [15:0] RECORD_BYTES = 16'h0012;
    localparam logic [15:0] AN_HDR_BYTES = 16'h0003;
    localparam logic [15:0] DIG_SECT_LEN = 16'h0004;
    localparam logic [15:0] SER_SECT_LEN = 16'h0004;
    localparam logic [15:0] FRAME_FIXED_BYTES = 16'h0003;
    localparam logic [4:0] HEAD_LAST = 5'h05;
    localparam logic [4:0] RECORD_LAST = 5'h11;
    localparam logic [4:0] TAIL_LAST = 5'h07;
    localparam logic [15:0] RAW_LOW_RESET = 16'hffff;
    localparam logic [15:0] RAW_HIGH_RESET = 16'h0000;
    localparam logic [31:0] CONV_LOW_RESET = 32'h7f800000;
    localparam logic [31:0] CONV_HIGH_RESET = 32'hff800000;
    localparam logic [31:0] INTERVAL_RESET = 32'h00000000;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_HEAD = 2'h1,
        ST_RECORD = 2'h3,
        ST_TAIL = 2'h2
    } frame_state_t;
endpackage : io_status_pkg
